// File: dual_timer_pkg.sv
/*
  dual_timer_pkg: register map, field positions, reset values and
  clock-select codes shared by the dual timer pair.
  assumes a byte-wide register port driven by a simple cpu master.
*/
package dual_timer_pkg;

  // ------------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_A_MODE    = 4'h0;
  localparam logic [3:0] ADDR_A_CMP     = 4'h1;
  localparam logic [3:0] ADDR_A_CLKSEL  = 4'h2;
  localparam logic [3:0] ADDR_A_COUNT   = 4'h3;
  localparam logic [3:0] ADDR_B_MODE    = 4'h4;
  localparam logic [3:0] ADDR_B_CMP     = 4'h5;
  localparam logic [3:0] ADDR_B_CLKSEL  = 4'h6;
  localparam logic [3:0] ADDR_B_COUNT   = 4'h7;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;

  // ------------------------------------------------------------------
  // mode control fields
  // ------------------------------------------------------------------
  localparam int BIT_OUT_EN    = 0;
  localparam int BIT_ACT_LVL   = 1;
  localparam int BIT_LVL_RST   = 2;
  localparam int BIT_LVL_SET   = 3;
  localparam int BIT_CASCADE   = 4;
  localparam int BIT_PWM_MODE  = 6;
  localparam int BIT_RUN       = 7;

  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] CMP_RESET    = 8'h00;
  localparam logic [2:0] CLKSEL_RESET = 3'h0;

  // ------------------------------------------------------------------
  // clock select codes: event edges or system clock divided by 2^k
  // ------------------------------------------------------------------
  localparam logic [2:0] SEL_EV_FALL = 3'h0;
  localparam logic [2:0] SEL_EV_RISE = 3'h1;
  localparam int         PRESC_W     = 12;

endpackage : dual_timer_pkg

// File: timer_channel.sv
/*
  timer_channel: one 8-bit counter with compare shadow and output
  flip-flop, pwm or clear-on-match behaviour.
  assumes the parent supplies a one-cycle count enable pulse.
*/
`timescale 1ns/1ns
module timer_channel
  import dual_timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // control
  input  wire logic             run,
  input  wire logic             pwm_mode,
  input  wire logic             active_high,
  input  wire logic             cmp_wr,
  input  wire logic [WIDTH-1:0] cmp_wdata,
  input  wire logic             count_en,
  input  wire logic             ext_clear,
  input  wire logic             use_ext_clear,
  input  wire logic             lvl_set,
  input  wire logic             lvl_reset,
  // state
  output logic      [WIDTH-1:0] count_r,
  output logic      [WIDTH-1:0] cmp_r,
  output logic                  match,
  output logic                  wrap,
  output logic                  level_r
);

  logic [WIDTH-1:0] cmp_shadow_r;
  logic             seen_ovf_r;
  logic             running;
  logic [WIDTH-1:0] count_nxt;

  assign running   = run && count_en;
  assign match     = running && (count_r == cmp_r);
  assign wrap      = running && (count_r == {WIDTH{1'b1}});
  assign count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};

  // pending compare only loaded at overflow while pwm runs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_shadow_r <= CMP_RESET;
      cmp_r        <= CMP_RESET;
    end else begin
      if (cmp_wr)
        cmp_shadow_r <= cmp_wdata;
      if (cmp_wr && !(run && pwm_mode))
        cmp_r <= cmp_wdata;
      else if (run && pwm_mode && wrap)
        cmp_r <= cmp_shadow_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      count_r <= '0;
    else if (!run)
      count_r <= '0;
    else if (use_ext_clear ? ext_clear : (match && !pwm_mode))
      count_r <= '0;
    else if (running)
      count_r <= count_nxt;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      seen_ovf_r <= 1'b0;
    else if (!run)
      seen_ovf_r <= 1'b0;
    else if (wrap)
      seen_ovf_r <= 1'b1;
  end

  // output flip-flop holds the active flag; polarity applied by parent
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      level_r <= 1'b0;
    else if (!run && lvl_set && !lvl_reset)
      level_r <= 1'b1;
    else if (!run && lvl_reset && !lvl_set)
      level_r <= 1'b0;
    else if (pwm_mode && !run)
      level_r <= 1'b0;
    else if (pwm_mode && wrap)
      level_r <= 1'b1;
    else if (pwm_mode && !seen_ovf_r)
      level_r <= 1'b0;
    else if (pwm_mode && match)
      level_r <= 1'b0;
    else if (!pwm_mode && match)
      level_r <= !level_r;
  end

  chk_pwm_wait_ovf : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    pwm_mode && run && !seen_ovf_r && !wrap |=> !level_r)
    else $error("pwm active before first overflow");

endmodule : timer_channel

// File: dual_timer_pwm_cascade.sv
/*
  dual_timer_pwm_cascade: two 8-bit timers with pwm outputs and a
  16-bit cascade interval mode, reached over a byte register port.
  assumes ref_clk at 100 MHz and synchronous event and port inputs.
*/
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns

// Notes on behaviour
// - pwm pulse width on each output follows its 8-bit compare value.
// - mode bit 1 selects the pulse's active level.
// - mode bit 0 enables the pulse onto its output pin.
// - each counter uses its own clock select when not cascaded.
// - writing mode bit 7 high starts the counter.
// - after start the output stays inactive until first overflow.
// - each overflow drives active level until count equals compare.
// - after match output is inactive until next overflow, repeating.
// - clearing the run bit forces a pwm output inactive unless level set is high and level reset low.
// - compare writes during pwm take effect after next overflow.
// - timer b mode bit 4 joins counters into sixteen bits.
// - cascaded pair repeatedly interrupts at the compare interval.
// - timer a compare is low byte, timer b compare high byte.
// - in cascade only timer a clock select picks the count clock.
// - on 16-bit match raise timer a interrupt and clear both.
// - timer b still interrupts on its byte match; software masks it.
// - in cascade timer a run bit alone starts and stops counting.
// - event clock in cascade counts input edges, up to 2^16.
// - level set and level reset bits preset the output flip-flop.
module dual_timer_pwm_cascade
  import dual_timer_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // event inputs
  input  wire logic       timer_a_event_input,
  input  wire logic       timer_b_event_input,
  // pulse outputs and match events
  output logic            timer_a_output_pin,
  output logic            timer_b_output_pin,
  output logic            timer_a_match_irq,
  output logic            timer_b_match_irq
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] timer_a_mode_control_r;
  logic [7:0] timer_b_mode_control_r;
  logic [2:0] timer_a_clock_select_r;
  logic [2:0] timer_b_clock_select_r;
  logic [7:0] reg_rdata_nxt;

  logic [PRESC_W-1:0] presc_r;
  logic [PRESC_W-1:0] presc_nxt;
  logic               ev_a_d_r;
  logic               ev_b_d_r;

  logic       wr_a_mode;
  logic       wr_b_mode;
  logic       wr_a_cmp;
  logic       wr_b_cmp;
  logic       cascade_mode_select;
  logic       timer_a_run_enable;
  logic       timer_b_run_enable;
  logic       run_b;
  logic       tick_a;
  logic       tick_b;
  logic       en_b;
  logic [7:0] count_a;
  logic [7:0] count_b;
  logic [7:0] cmp_a;
  logic [7:0] cmp_b;
  logic       match_a;
  logic       match_b;
  logic       wrap_a;
  logic       lvl_a;
  logic       lvl_b;
  logic       match16;

  // ------------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------------
  assign wr_a_mode = reg_wr && (reg_addr == ADDR_A_MODE);
  assign wr_b_mode = reg_wr && (reg_addr == ADDR_B_MODE);
  assign wr_a_cmp  = reg_wr && (reg_addr == ADDR_A_CMP);
  assign wr_b_cmp  = reg_wr && (reg_addr == ADDR_B_CMP);

  assign cascade_mode_select = timer_b_mode_control_r[BIT_CASCADE];
  assign timer_a_run_enable  = timer_a_mode_control_r[BIT_RUN];
  assign timer_b_run_enable  = timer_b_mode_control_r[BIT_RUN];
  // in cascade, only timer a's run bit gates the pair
  assign run_b = cascade_mode_select ? timer_a_run_enable
                                     : timer_b_run_enable;

  // ------------------------------------------------------------------
  // count clock selection
  // ------------------------------------------------------------------
  assign presc_nxt = presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};

  // one-cycle pulse when prescaler bit k-1 carries into bit k
  function automatic logic div_tick(input logic [2:0] sel,
                                    input logic [PRESC_W-1:0] p,
                                    input logic ev, input logic ev_d);
    logic [3:0] k;
    k = 4'h0;
    case (sel)
      3'h2:    k = 4'h3;
      3'h3:    k = 4'h5;
      3'h4:    k = 4'h7;
      3'h5:    k = 4'h8;
      3'h6:    k = 4'h9;
      3'h7:    k = 4'hb;
      default: k = 4'h0;
    endcase
    if (sel == SEL_EV_FALL)
      div_tick = ev_d && !ev;
    else if (sel == SEL_EV_RISE)
      div_tick = !ev_d && ev;
    else
      div_tick = (p & ((12'h001 << k) - 12'h001)) == '0;
  endfunction : div_tick

  assign tick_a = div_tick(timer_a_clock_select_r, presc_r,
                           timer_a_event_input, ev_a_d_r);
  assign tick_b = div_tick(timer_b_clock_select_r, presc_r,
                           timer_b_event_input, ev_b_d_r);
  assign en_b   = cascade_mode_select ? wrap_a : tick_b;

  assign match16 = cascade_mode_select && tick_a && timer_a_run_enable
                   && (count_a == cmp_a) && (count_b == cmp_b);

  // ------------------------------------------------------------------
  // channels
  // ------------------------------------------------------------------
  timer_channel #(.WIDTH(8)) u_chan_a (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .run           (timer_a_run_enable),
    .pwm_mode      (timer_a_mode_control_r[BIT_PWM_MODE]),
    .active_high   (timer_a_mode_control_r[BIT_ACT_LVL]),
    .cmp_wr        (wr_a_cmp),
    .cmp_wdata     (reg_wdata),
    .count_en      (tick_a),
    .ext_clear     (match16),
    .use_ext_clear (cascade_mode_select),
    .lvl_set       (timer_a_mode_control_r[BIT_LVL_SET]),
    .lvl_reset     (timer_a_mode_control_r[BIT_LVL_RST]),
    .count_r       (count_a),
    .cmp_r         (cmp_a),
    .match         (match_a),
    .wrap          (wrap_a),
    .level_r       (lvl_a)
  );

  timer_channel #(.WIDTH(8)) u_chan_b (
    .ref_clk       (ref_clk),
    .rst_b         (rst_b),
    .run           (run_b),
    .pwm_mode      (timer_b_mode_control_r[BIT_PWM_MODE]
                    && !cascade_mode_select),
    .active_high   (timer_b_mode_control_r[BIT_ACT_LVL]),
    .cmp_wr        (wr_b_cmp),
    .cmp_wdata     (reg_wdata),
    .count_en      (en_b),
    .ext_clear     (match16),
    .use_ext_clear (cascade_mode_select),
    .lvl_set       (timer_b_mode_control_r[BIT_LVL_SET]),
    .lvl_reset     (timer_b_mode_control_r[BIT_LVL_RST]),
    .count_r       (count_b),
    .cmp_r         (cmp_b),
    .match         (),
    .wrap          (),
    .level_r       (lvl_b)
  );

  // b's byte match is seen on a's tick too, since b only moves on wraps
  assign match_b = cascade_mode_select
                   ? (run_b && tick_a && count_b == cmp_b)
                   : (run_b && tick_b && count_b == cmp_b);

  // ------------------------------------------------------------------
  // register writes and read mux
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_a_mode_control_r <= MODE_RESET;
      timer_b_mode_control_r <= MODE_RESET;
      timer_a_clock_select_r <= CLKSEL_RESET;
      timer_b_clock_select_r <= CLKSEL_RESET;
    end else begin
      if (wr_a_mode)
        timer_a_mode_control_r <= reg_wdata;
      if (wr_b_mode)
        timer_b_mode_control_r <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_A_CLKSEL)
        timer_a_clock_select_r <= reg_wdata[2:0];
      if (reg_wr && reg_addr == ADDR_B_CLKSEL)
        timer_b_clock_select_r <= reg_wdata[2:0];
    end
  end

  always_comb begin
    reg_rdata_nxt = 8'h00;
    case (reg_addr)
      ADDR_A_MODE:   reg_rdata_nxt = timer_a_mode_control_r;
      ADDR_A_CMP:    reg_rdata_nxt = cmp_a;
      ADDR_A_CLKSEL: reg_rdata_nxt = {5'h00, timer_a_clock_select_r};
      ADDR_A_COUNT:  reg_rdata_nxt = count_a;
      ADDR_B_MODE:   reg_rdata_nxt = timer_b_mode_control_r;
      ADDR_B_CMP:    reg_rdata_nxt = cmp_b;
      ADDR_B_CLKSEL: reg_rdata_nxt = {5'h00, timer_b_clock_select_r};
      ADDR_B_COUNT:  reg_rdata_nxt = count_b;
      ADDR_STATUS:   reg_rdata_nxt = {6'h00, lvl_b, lvl_a};
      default:       reg_rdata_nxt = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // outputs, prescaler and edge history
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata          <= 8'h00;
      presc_r            <= '0;
      ev_a_d_r           <= 1'b0;
      ev_b_d_r           <= 1'b0;
      timer_a_output_pin <= 1'b0;
      timer_b_output_pin <= 1'b0;
      timer_a_match_irq  <= 1'b0;
      timer_b_match_irq  <= 1'b0;
    end else begin
      reg_rdata          <= reg_rd ? reg_rdata_nxt : 8'h00;
      presc_r            <= presc_nxt;
      ev_a_d_r           <= timer_a_event_input;
      ev_b_d_r           <= timer_b_event_input;
      // disabled output rests low; active level flips the flop sense
      timer_a_output_pin <= timer_a_mode_control_r[BIT_OUT_EN] &&
        (lvl_a ~^ timer_a_mode_control_r[BIT_ACT_LVL]);
      timer_b_output_pin <= timer_b_mode_control_r[BIT_OUT_EN] &&
        (lvl_b ~^ timer_b_mode_control_r[BIT_ACT_LVL]);
      timer_a_match_irq  <= cascade_mode_select ? match16
                            : match_a;
      timer_b_match_irq  <= match_b;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_match16;
    match16;
  endsequence

  chk_cascade_clear_both : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    s_match16 |=> count_a == 8'h00 && count_b == 8'h00 && timer_a_match_irq)
    else $error("cascade match did not clear both and interrupt");

  chk_stop_inactive : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    $fell(timer_a_run_enable) && timer_a_mode_control_r[BIT_PWM_MODE]
    && !timer_a_mode_control_r[BIT_LVL_SET] |=> !lvl_a)
    else $error("pwm output not inactive after stop");

  chk_start_count : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !timer_a_run_enable |=> count_a == 8'h00)
    else $error("counter moved while stopped");

  chk_cascade_carry : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    cascade_mode_select && wrap_a && !match16
    |=> count_b == $past(count_b) + 8'h01)
    else $error("high byte missed carry");

  chk_pwm_overflow : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    timer_a_mode_control_r[BIT_PWM_MODE] && wrap_a
    && !wr_a_mode |=> lvl_a)
    else $error("pwm not active after overflow");

  chk_out_disable : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !timer_a_mode_control_r[BIT_OUT_EN] |=> !timer_a_output_pin)
    else $error("timer a pin not low while disabled");

  chk_b_out_disable : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !timer_b_mode_control_r[BIT_OUT_EN] |=> !timer_b_output_pin)
    else $error("timer b pin not low while disabled");

  chk_active_level : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    timer_a_mode_control_r[BIT_OUT_EN] && timer_a_mode_control_r[BIT_ACT_LVL]
    |=> timer_a_output_pin == $past(lvl_a))
    else $error("active high pin does not follow flop");

  chk_cmp_held : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    timer_a_run_enable && timer_a_mode_control_r[BIT_PWM_MODE] && !wrap_a
    |=> $stable(cmp_a))
    else $error("compare changed before overflow");

  chk_irq_only_match : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    cascade_mode_select && !match16 |=> !timer_a_match_irq)
    else $error("cascade interrupt without 16-bit match");

  chk_cascade_stop : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    cascade_mode_select && !timer_a_run_enable |=> count_b == 8'h00)
    else $error("high byte counts while pair stopped");

  chk_high_byte_hold : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    cascade_mode_select && timer_a_run_enable && !wrap_a && !match16
    |=> $stable(count_b))
    else $error("high byte moved without carry");

  chk_level_preset : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    !timer_a_run_enable && timer_a_mode_control_r[BIT_LVL_SET]
    && !timer_a_mode_control_r[BIT_LVL_RST] |=> lvl_a)
    else $error("level set did not preset flop");

  chk_b_byte_irq : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    cascade_mode_select && run_b && tick_a && count_b == cmp_b
    |=> timer_b_match_irq)
    else $error("high byte match gave no interrupt");

  chk_pwm_free_run : assert property (@(posedge ref_clk)
    disable iff (!rst_b)
    timer_a_mode_control_r[BIT_PWM_MODE] && !cascade_mode_select && match_a
    |=> count_a == $past(count_a) + 8'h01)
    else $error("pwm match disturbed the count");

endmodule : dual_timer_pwm_cascade

// File: lpf_model.sv
/*
  lpf_model: behavioural stand-in for the low-pass filter that sits on
  a pulse output pin; it integrates the pin as a count of high cycles.
  assumes the pin reaches it directly, with the port latch and port
  mode already cleared by software.
*/
`timescale 1ns/1ns
module lpf_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // filter input and discharge
  input  wire logic        pin,
  input  wire logic        clear,
  // integrated level
  output logic      [15:0] high_cnt
);
  // ------------------------------------------------------------------
  // integrator
  // ------------------------------------------------------------------
  // a count of high cycles stands in for the averaged voltage; an
  // unknown pin never adds, so a floating output reads as no charge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_cnt <= 16'h0000;
    end else if (clear) begin
      high_cnt <= 16'h0000;
    end else if (pin === 1'b1) begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end
endmodule : lpf_model

// File: dual_timer_pwm_cascade_test.sv
/*
  dual_timer_pwm_cascade_test: register-level tests of pwm and cascade
  behaviour, with a filter model on the first pulse output.
  assumes the register map and mode bits of dual_timer_pkg.
*/
`timescale 1ns/1ns
module dual_timer_pwm_cascade_test;
  import dual_timer_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ev_a = 1'b0;
  logic        ev_b = 1'b0;
  logic        lpf_clear = 1'b0;
  logic [7:0]  reg_rdata;
  logic        pin_a;
  logic        pin_b;
  logic        irq_a;
  logic        irq_b;
  logic [15:0] high_a;
  logic [7:0]  rd_val;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          a_irqs = 0;
  int          b_irqs = 0;
  int          base_a;
  int          base_b;
  always #5 ref_clk = ~ref_clk;
  dual_timer_pwm_cascade u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_a_event_input(ev_a),
    .timer_b_event_input(ev_b), .timer_a_output_pin(pin_a),
    .timer_b_output_pin(pin_b), .timer_a_match_irq(irq_a),
    .timer_b_match_irq(irq_b));
  lpf_model u_lpf (
    .ref_clk(ref_clk), .rst_b(rst_b), .pin(pin_a), .clear(lpf_clear),
    .high_cnt(high_a));
  always @(posedge ref_clk) begin
    if (irq_a === 1'b1) a_irqs <= a_irqs + 1;
    if (irq_b === 1'b1) b_irqs <= b_irqs + 1;
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task print_verdict;
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task check(input string what, input logic [7:0] exp,
             input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // filter readings only: a window may straddle a period edge
  task near(input string what, input int exp, input logic [15:0] got,
            input int tol);
    comparisons++;
    if (^got === 1'bx || got < exp - tol || got > exp + tol) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task rd_chk(input logic [3:0] a, input logic [7:0] exp,
              input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
    check(what, exp, rd_val);
  endtask : rd_chk
  task wait_pin_a(input logic lvl);
    int i;
    for (i = 0; i < 3000 && pin_a !== lvl; i++) @(posedge ref_clk);
    if (pin_a !== lvl) begin
      n_mismatch++;
      $display("[ERR] pin_a wait expected %b seen %b", lvl, pin_a);
      print_verdict;
    end
  endtask : wait_pin_a
  // one pwm period is 256 ticks of fclk/8, 2048 cycles
  task measure(input int cycles);
    @(posedge ref_clk);
    lpf_clear <= 1'b1;
    @(posedge ref_clk);
    lpf_clear <= 1'b0;
    repeat (cycles - 1) @(posedge ref_clk);
    #1;
  endtask : measure
  task ev_pulses(input int n, input bit on_b);
    repeat (n) begin
      @(posedge ref_clk);
      if (on_b) ev_b <= 1'b1;
      else ev_a <= 1'b1;
      repeat (2) @(posedge ref_clk);
      ev_a <= 1'b0;
      ev_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask : ev_pulses
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 10; k++) rd_chk(k[3:0], 8'h00, "reset read");
    wr(4'h9, 8'hff);
    rd_chk(4'h9, 8'h00, "unmapped read");
    wr(ADDR_A_MODE, 8'h08);
    rd_chk(ADDR_STATUS, 8'h01, "level set");
    wr(ADDR_A_MODE, 8'h04);
    rd_chk(ADDR_STATUS, 8'h00, "level reset");
    wr(ADDR_A_CLKSEL, 8'h02);
    wr(ADDR_A_CMP, 8'h40);
    wr(ADDR_A_MODE, 8'hc3);
    measure(1600);
    near("inactive before wrap", 0, high_a, 0);
    wait_pin_a(1'b1);
    // new compare lands just after an overflow: old width must hold one more period
    wr(ADDR_A_CMP, 8'hc0);
    measure(2048);
    near("pwm width old cmp", 'h40 * 8, high_a, 16);
    measure(2048);
    near("pwm width new cmp", 'hc0 * 8, high_a, 16);
    wr(ADDR_A_MODE, 8'h43);
    repeat (2) @(posedge ref_clk);
    #1;
    check("stop active high", 8'h00, {7'h00, pin_a});
    wr(ADDR_A_MODE, 8'h41);
    repeat (2) @(posedge ref_clk);
    #1;
    check("stop active low", 8'h01, {7'h00, pin_a});
    wr(ADDR_A_MODE, 8'hc1);
    wait_pin_a(1'b0);
    measure(2048);
    near("active low width", 2048 - 'hc0 * 8, high_a, 16);
    wr(ADDR_A_MODE, 8'hc2);
    measure(2048);
    near("output disabled", 0, high_a, 0);
    wr(ADDR_A_MODE, 8'h00);
    wr(ADDR_B_CMP, 8'hff);
    wr(ADDR_B_CLKSEL, {5'h00, SEL_EV_FALL});
    wr(ADDR_B_MODE, 8'h80);
    wr(ADDR_A_MODE, 8'h80);
    ev_pulses(5, 1'b1);
    rd_chk(ADDR_B_COUNT, 8'h05, "b event count");
    wr(ADDR_A_MODE, 8'h00);
    wr(ADDR_B_MODE, 8'h0b);
    repeat (2) @(posedge ref_clk);
    #1;
    check("b level set pin", 8'h01, {7'h00, pin_b});
    wr(ADDR_A_CMP, 8'h02);
    wr(ADDR_B_CMP, 8'h01);
    wr(ADDR_A_CLKSEL, {5'h00, SEL_EV_RISE});
    wr(ADDR_B_CLKSEL, 8'h02);
    wr(ADDR_B_MODE, 8'h90);
    wr(ADDR_A_MODE, 8'h80);
    base_a = a_irqs;
    base_b = b_irqs;
    ev_pulses(258, 1'b0);
    rd_chk(ADDR_A_COUNT, 8'h02, "cascade low byte");
    rd_chk(ADDR_B_COUNT, 8'h01, "cascade high byte");
    check("no early match", 8'h00, 8'(a_irqs - base_a));
    ev_pulses(1, 1'b0);
    check("cascade match", 8'h01, 8'(a_irqs - base_a));
    rd_chk(ADDR_A_COUNT, 8'h00, "low cleared");
    rd_chk(ADDR_B_COUNT, 8'h00, "high cleared");
    check("b byte match", 8'h01, {7'h00, b_irqs > base_b});
    ev_pulses(259, 1'b0);
    check("repeat interval", 8'h02, 8'(a_irqs - base_a));
    wr(ADDR_A_MODE, 8'h00);
    ev_pulses(3, 1'b0);
    rd_chk(ADDR_A_COUNT, 8'h00, "cascade stopped");
    print_verdict;
  end
endmodule : dual_timer_pwm_cascade_test
